/* File: drc_defs.svh */
// Purpose: timing constants for the page-mode dram controller
// Assumes: 10 MHz system clock, fastest speed grade
// Notes: times in ns, counts derived in cycles
`ifndef DRC_DEFS_SVH
`define DRC_DEFS_SVH
`define DRC_CLK_NS        100
`define DRC_T_RP_NS       80
`define DRC_T_RAS_NS      100
`define DRC_T_RAS_MAX_NS  10000
`define DRC_T_CAS_NS      55
`define DRC_T_RCD_NS      15
`define DRC_T_CWD_NS      50
`define DRC_T_WP_NS       30
`define DRC_T_REF_NS      2000000
`define DRC_T_PWRUP_NS    100000
`define DRC_REF_ROWS      128
`define DRC_INIT_CYCLES   8
// least times round up
`define DRC_CYC_MIN(ns)   (((ns) + `DRC_CLK_NS - 1) / `DRC_CLK_NS)
// longest times round down
`define DRC_CYC_MAX(ns)   ((ns) / `DRC_CLK_NS)
`define DRC_RP_CYC        `DRC_CYC_MIN(`DRC_T_RP_NS)
`define DRC_CAS_CYC       `DRC_CYC_MIN(`DRC_T_CAS_NS)
`define DRC_CWD_CYC       `DRC_CYC_MIN(`DRC_T_CWD_NS)
`define DRC_RAS_MAX_CYC   `DRC_CYC_MAX(`DRC_T_RAS_MAX_NS)
`define DRC_REF_CYC       (`DRC_CYC_MAX(`DRC_T_REF_NS) / `DRC_REF_ROWS)
`define DRC_PWRUP_CYC     `DRC_CYC_MIN(`DRC_T_PWRUP_NS)
`endif

/* File: drc_pkg.sv */
// Purpose: types for the page-mode dram controller
// Assumes: 8 multiplexed address lines, 16-bit word address
// Notes: none
package drc_pkg;
	typedef enum logic [1:0] {
		DRC_OP_READ  = 2'b00,
		DRC_OP_WRITE = 2'b01,
		DRC_OP_RMW   = 2'b10
	} drc_op_t;

	typedef struct packed {
		drc_op_t     op;
		logic [15:0] addr;
		logic        wdata;
		logic        keep_open;
	} drc_req_t;

	typedef struct packed {
		logic       ras_b;
		logic       cas_b;
		logic       we_b;
		logic [7:0] mux_addr_lines;
		logic       din;
	} drc_pins_t;

	typedef enum logic [3:0] {
		DRC_ST_PWRUP = 4'b0000,
		DRC_ST_INIT  = 4'b0001,
		DRC_ST_IDLE  = 4'b0010,
		DRC_ST_ROW   = 4'b0011,
		DRC_ST_COL   = 4'b0100,
		DRC_ST_CAS   = 4'b0101,
		DRC_ST_MWR   = 4'b0110,
		DRC_ST_PAGE  = 4'b0111,
		DRC_ST_PRE   = 4'b1000,
		DRC_ST_REF   = 4'b1001
	} drc_state_t;
endpackage : drc_pkg

/* File: drc_ctrl.sv */
// Purpose: controller driving a 64K x 1 page-mode dram through its pins
// Assumes: 10 MHz clock; dram output sampled through three flip-flops
// Notes: one request at a time; refresh has priority between accesses
// How it works
// - row half put on address lines first, then column half
// - page mode holds row strobe low, cycles column strobe per access
// - 128 row refreshes issued within every 2 ms
// - random cycles spaced at least 190 ns apart
// - read-modify-write cycle given at least 215 ns
// - row strobe held high at least 80 ns between cycles
// - row strobe low at least 100 ns, at most 10,000 ns
// - column strobe low at least 55 ns, at most 10,000 ns
// - column strobe falls at least 15 ns after row strobe
// - write input low at least 30 ns per write
// - read-modify-write write falls at least 50 ns after column strobe
// - wait 100 us after power-up, then 8 row strobe cycles
// - reads keep write input high throughout
// - row latched with column strobe high, then column latched
`timescale 1ns/1ps
`include "drc_defs.svh"
module drc_ctrl #(
	parameter int PWRUP_CYC = `DRC_PWRUP_CYC,
	parameter int REF_CYC   = `DRC_REF_CYC
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst_b,
	input  wire logic             i_req_valid,
	input  wire drc_pkg::drc_req_t i_req,
	output logic                  o_req_ready,
	output logic                  o_rdata_valid,
	output logic                  o_rdata,
	output logic                  o_init_done,
	output drc_pkg::drc_pins_t    o_pins,
	input  wire logic             i_dout
);
	import drc_pkg::*;

	localparam int CNT_W = 16;
	initial begin
		if (PWRUP_CYC < 1 || PWRUP_CYC >= (1 << CNT_W) || REF_CYC < 8 || REF_CYC >= (1 << CNT_W))
			$error("drc_ctrl: counts out of range");
	end

	localparam logic [CNT_W-1:0] RP_C  = CNT_W'(`DRC_RP_CYC);
	localparam logic [CNT_W-1:0] CAS_C = CNT_W'(`DRC_CAS_CYC);
	localparam logic [CNT_W-1:0] CWD_C = CNT_W'(`DRC_CWD_CYC);
	// leave margin for the closing cycles of the page: col, cas, late write, release
	localparam logic [CNT_W-1:0] RASMX = CNT_W'(`DRC_RAS_MAX_CYC - 12);
	localparam logic [CNT_W-1:0] PWR_C = CNT_W'(PWRUP_CYC);
	localparam logic [CNT_W-1:0] REF_C = CNT_W'(REF_CYC);
	localparam logic [3:0]       INI_C = 4'(`DRC_INIT_CYCLES);

	drc_state_t       state;
	drc_state_t       next_state;
	logic [CNT_W-1:0] tcnt;
	logic [CNT_W-1:0] rascnt;
	logic [CNT_W-1:0] refcnt;
	logic [3:0]       initcnt;
	logic [7:0]       refrow;
	logic             ref_pend;
	drc_req_t         cur;
	logic             page_open;
	logic [7:0]       open_row;
	logic [2:0]       dsync;
	logic             dout_s;

	wire t_done   = (tcnt == '0);
	wire ref_tick = (refcnt == '0);
	wire take     = o_req_ready && i_req_valid;
	wire is_read  = (cur.op == DRC_OP_READ);
	wire is_rmw   = (cur.op == DRC_OP_RMW);
	wire same_row = (i_req.addr[15:8] == open_row);
	wire ras_long = (rascnt >= RASMX);
	// page may stay open only with no refresh due and ras time left
	wire page_ok  = page_open && !ref_pend && !ras_long;

	assign o_req_ready = (state == DRC_ST_IDLE && !ref_pend)
	                  || (state == DRC_ST_PAGE && page_ok && same_row);
	// precharge between init cycles still belongs to the start-up sequence
	assign o_init_done = (state != DRC_ST_PWRUP) && (state != DRC_ST_INIT)
	                  && !(state == DRC_ST_PRE && initcnt != 4'h0);

	// second and third stage agree before the sampled level changes
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			dsync  <= 3'h0;
			dout_s <= 1'b0;
		end else begin
			dsync  <= {dsync[1:0], i_dout};
			dout_s <= (dsync[1] == dsync[2]) ? dsync[2] : dout_s;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			refcnt   <= '0;
			ref_pend <= 1'b0;
		end else begin
			refcnt   <= ref_tick ? REF_C - CNT_W'(1) : refcnt - CNT_W'(1);
			ref_pend <= ref_tick ? 1'b1 : (state == DRC_ST_REF ? 1'b0 : ref_pend);
		end
	end

	always_comb begin
		next_state = state;
		unique case (state)
			DRC_ST_PWRUP: if (t_done) next_state = DRC_ST_PRE;
			DRC_ST_INIT:  if (t_done) next_state = DRC_ST_PRE;
			DRC_ST_IDLE: begin
				if (ref_pend)  next_state = DRC_ST_REF;
				else if (take) next_state = DRC_ST_ROW;
			end
			DRC_ST_ROW:   if (t_done) next_state = DRC_ST_COL;
			DRC_ST_COL:   next_state = DRC_ST_CAS;
			DRC_ST_CAS: begin
				if (t_done) next_state = is_rmw ? DRC_ST_MWR : DRC_ST_PAGE;
			end
			DRC_ST_MWR:   if (t_done) next_state = DRC_ST_PAGE;
			DRC_ST_PAGE: begin
				if (take)          next_state = DRC_ST_COL;
				else if (!page_ok || !cur.keep_open || !same_row || i_req_valid)
					next_state = DRC_ST_PRE;
			end
			DRC_ST_PRE: begin
				if (t_done) next_state = (initcnt != '0) ? DRC_ST_INIT : DRC_ST_IDLE;
			end
			DRC_ST_REF:   if (t_done) next_state = DRC_ST_PRE;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			state     <= DRC_ST_PWRUP;
			tcnt      <= PWR_C;
			rascnt    <= '0;
			initcnt   <= 4'h0;
			refrow    <= 8'h00;
			cur       <= '0;
			page_open <= 1'b0;
			open_row  <= 8'h00;
			o_pins    <= '{ras_b: 1'b1, cas_b: 1'b1, we_b: 1'b1, mux_addr_lines: 8'h00, din: 1'b0};
			o_rdata       <= 1'b0;
			o_rdata_valid <= 1'b0;
		end else begin
			state         <= next_state;
			o_rdata_valid <= 1'b0;
			rascnt        <= o_pins.ras_b ? '0 : rascnt + CNT_W'(1);
			tcnt          <= t_done ? '0 : tcnt - CNT_W'(1);
			unique case (next_state)
				// power-up pause then eight row cycles
				DRC_ST_PRE: if (state != DRC_ST_PRE) begin
					o_pins.ras_b <= 1'b1;
					o_pins.cas_b <= 1'b1;
					o_pins.we_b  <= 1'b1;
					// refresh row set up while ras is high, so it is stable when ras falls
					o_pins.mux_addr_lines <= refrow;
					page_open    <= 1'b0;
					tcnt         <= RP_C;
					if (state == DRC_ST_PWRUP) initcnt <= INI_C;
					else if (state == DRC_ST_INIT) initcnt <= initcnt - 4'h1;
				end
				DRC_ST_INIT: if (state != DRC_ST_INIT) begin
					o_pins.ras_b <= 1'b0;
					tcnt         <= CAS_C;
				end
				DRC_ST_REF: if (state != DRC_ST_REF) begin
					o_pins.ras_b          <= 1'b0;
					refrow                <= refrow + 8'h01;
					// ras low at least 100 ns
					tcnt                  <= CAS_C;
				end
				DRC_ST_ROW: if (state != DRC_ST_ROW) begin
					cur                   <= i_req;
					o_pins.mux_addr_lines <= i_req.addr[15:8];
					open_row              <= i_req.addr[15:8];
					tcnt                  <= CNT_W'(1);
				end else begin
					// ras falls a cycle after the row half settles, so the address holds
					o_pins.ras_b          <= 1'b0;
				end
				DRC_ST_COL: begin
					if (state == DRC_ST_PAGE) cur <= i_req;
					o_pins.ras_b          <= 1'b0;
					o_pins.cas_b          <= 1'b1;
					// early write settles a cycle before cas falls
					o_pins.we_b           <= (state == DRC_ST_PAGE) ? (i_req.op != DRC_OP_WRITE)
					                                                : (cur.op != DRC_OP_WRITE);
					o_pins.mux_addr_lines <= (state == DRC_ST_PAGE) ? i_req.addr[7:0] : cur.addr[7:0];
					o_pins.din            <= (state == DRC_ST_PAGE) ? i_req.wdata : cur.wdata;
					page_open             <= 1'b1;
				end
				DRC_ST_CAS: if (state != DRC_ST_CAS) begin
					// cas two cycles after ras falls
					o_pins.cas_b <= 1'b0;
					// cas pulse minimum
					// three more cycles so the data sampler has settled before cas rises
					tcnt         <= CAS_C + CNT_W'(3);
				end
				DRC_ST_MWR: if (state != DRC_ST_MWR) begin
					o_pins.we_b <= 1'b0;
					tcnt        <= CWD_C;
				end
				DRC_ST_PAGE: if (state == DRC_ST_CAS || state == DRC_ST_MWR) begin
					o_rdata       <= dout_s;
					o_rdata_valid <= is_read || is_rmw;
					// column strobe released, row kept open
					o_pins.cas_b  <= 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// random cycle spacing covered by the state walk
	// rmw adds a write phase to the same walk
	// ras access met since cas waits for it
	// full 16-bit address driven as row and column
endmodule : drc_ctrl

/* File: drc_dram_model.sv */
// Purpose: behavioural 64K x 1 page-mode dram for the controller bench
// Assumes: strobes and address come registered from the controller
// Notes: no cell decay is modelled, so refresh is only seen at the pins
`timescale 1ns/1ps
module drc_dram_model (
	input  wire logic               i_sys_clk,
	input  wire drc_pkg::drc_pins_t i_pins,
	output logic                    o_dout
);
	import drc_pkg::*;
	logic        mem [0:65535];
	logic [7:0]  row;
	logic [15:0] adr;
	logic        drive = 1'b0;
	logic        q;
	logic        junk = 1'b0;
	// row taken on row strobe, ras-only refresh
	always @(negedge i_pins.ras_b) row = i_pins.mux_addr_lines;
	// any column of open row, early write stays off
	always @(negedge i_pins.cas_b) begin
		adr = {row, i_pins.mux_addr_lines};
		q = mem[adr];
		drive = i_pins.we_b;
		if (!i_pins.we_b)
			mem[adr] = i_pins.din;
	end
	// late write: old data stays on the output meanwhile
	always @(negedge i_pins.we_b) if (!i_pins.cas_b) mem[adr] = i_pins.din;
	// floating output never repeats the last value
	always @(posedge i_sys_clk) junk <= ~junk;
	// data only while column strobe low
	assign o_dout = (!i_pins.cas_b && drive) ? q : junk;
endmodule : drc_dram_model

/* File: drc_ctrl_sva.sv */
// Purpose: pin timing checks for the dram controller
// Assumes: one clock, sync active-low reset
// Notes: the last taken request stands for the open access
`timescale 1ns/1ps
module drc_ctrl_sva #(
	parameter int PWRUP_CYC = 1000,
	parameter int REF_CYC   = 156
) (
	input wire logic               i_sys_clk,
	input wire logic               i_rst_b,
	input wire logic               i_req_valid,
	input wire drc_pkg::drc_req_t  i_req,
	input wire logic               o_req_ready,
	input wire logic               o_init_done,
	input wire drc_pkg::drc_pins_t o_pins
);
	import drc_pkg::*;
	drc_req_t req;
	int       n_up;
	int       n_hi;
	int       n_lo;
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			req <= '0;
			n_up <= 0;
			n_hi <= 0;
			n_lo <= 0;
		end else begin
			if (i_req_valid && o_req_ready)
				req <= i_req;
			if (n_up < PWRUP_CYC)
				n_up <= n_up + 1;
			n_hi <= o_pins.ras_b ? n_hi + 1 : 0;
			n_lo <= o_pins.ras_b ? 0 : n_lo + 1;
		end
	end
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	pwrup_wait_a: assert property (n_up < PWRUP_CYC - 1 |-> o_pins.ras_b && !o_init_done)
		else $error("row strobe during power-up pause");
	ref_gap_a: assert property (o_init_done |-> n_hi <= REF_CYC + 8)
		else $error("refresh gap too long");
	ras_max_a: assert property (n_lo <= 100)
		else $error("row strobe low too long");
	ras_cas_a: assert property ($fell(o_pins.cas_b) |-> !o_pins.ras_b && !$past(o_pins.ras_b))
		else $error("column strobe too soon");
	col_addr_a: assert property ($fell(o_pins.cas_b) |-> o_pins.mux_addr_lines == req.addr[7:0])
		else $error("wrong column half");
	read_we_a: assert property (!o_pins.cas_b && req.op == DRC_OP_READ |-> o_pins.we_b)
		else $error("write input low in read");
	early_we_a: assert property ($fell(o_pins.cas_b) && req.op == DRC_OP_WRITE |->
		!o_pins.we_b && !$past(o_pins.we_b)) else $error("write not early");
	rmw_late_a: assert property ($fell(o_pins.cas_b) && req.op == DRC_OP_RMW |->
		o_pins.we_b [*5] ##1 !o_pins.we_b) else $error("rmw write timing");
	we_lead_a: assert property ($rose(o_pins.cas_b) && req.op != DRC_OP_READ |-> !$past(o_pins.we_b))
		else $error("write input lead too short");
	cas_width_a: assert property ($fell(o_pins.cas_b) |-> ##[1:100] o_pins.cas_b)
		else $error("column strobe width");
	row_hold_a: assert property ($fell(o_pins.ras_b) |-> $stable(o_pins.mux_addr_lines))
		else $error("row half moved as row strobe fell");
	col_setup_a: assert property ($fell(o_pins.cas_b) |-> $stable(o_pins.mux_addr_lines))
		else $error("column half moved as column strobe fell");
endmodule : drc_ctrl_sva
bind drc_ctrl drc_ctrl_sva #(.PWRUP_CYC(PWRUP_CYC), .REF_CYC(REF_CYC)) u_sva (
	.i_sys_clk, .i_rst_b, .i_req_valid, .i_req, .o_req_ready, .o_init_done, .o_pins);

/* File: dram_64k_x1_page_mode_tb_top.sv */
// Purpose: self-checking bench for the page-mode dram controller
// Assumes: short sim counts for power-up pause and refresh tick
// Notes: the model starts unknown, so every read follows a write
`timescale 1ns/1ps
module dram_64k_x1_page_mode_tb_top;
	import drc_pkg::*;
	localparam int PW = 20;
	logic i_sys_clk, i_rst_b, i_req_valid, o_req_ready, o_rdata_valid, o_rdata, o_init_done;
	logic i_dout, rd;
	drc_req_t  i_req;
	drc_pins_t o_pins;
	int fails, num_checks;
	logic [15:0] adr [4] = '{16'h0000, 16'hffff, 16'h5a3c, 16'ha5c3};
	drc_ctrl #(.PWRUP_CYC(PW), .REF_CYC(PW)) DUT (.i_sys_clk, .i_rst_b, .i_req_valid, .i_req,
		.o_req_ready, .o_rdata_valid, .o_rdata, .o_init_done, .o_pins, .i_dout);
	drc_dram_model u_mem (.i_sys_clk, .i_pins(o_pins), .o_dout(i_dout));
	initial begin
		i_sys_clk = 0;
		forever #50 i_sys_clk = ~i_sys_clk;
	end
	task chk(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task req(input drc_op_t op, input logic [15:0] a, input logic d, input logic k);
		int n;
		n = 0;
		i_req_valid = 1;
		i_req = '{op, a, d, k};
		while (o_req_ready !== 1'b1 && n++ < 300) @(negedge i_sys_clk);
		@(negedge i_sys_clk);
		i_req_valid = 0;
		n = 0;
		while (op != DRC_OP_WRITE && o_rdata_valid !== 1'b1 && n++ < 50) @(negedge i_sys_clk);
		chk(n < 50, 1);
		rd = o_rdata;
		@(negedge i_sys_clk);
	endtask : req
	task t_init;
		int n;
		n = 0;
		repeat (PW - 2) @(negedge i_sys_clk);
		chk(o_init_done, 0);
		while (o_init_done !== 1'b1 && n++ < 300) @(negedge i_sys_clk);
		chk(o_init_done, 1);
		$display("done t_init");
	endtask : t_init
	task t_rw;
		for (int i = 0; i < 4; i++)
			req(DRC_OP_WRITE, adr[i], i[0], 0);
		for (int i = 0; i < 4; i++) begin
			req(DRC_OP_READ, adr[i], 0, 0);
			chk(rd, i[0]);
		end
		$display("done t_rw");
	endtask : t_rw
	task t_page;
		logic [7:0] col [3];
		col = '{8'h00, 8'h80, 8'hff};
		for (int i = 0; i < 3; i++)
			req(DRC_OP_WRITE, {8'h12, col[i]}, ~i[0], 1);
		for (int i = 0; i < 3; i++) begin
			req(DRC_OP_READ, {8'h12, col[i]}, 0, i < 2);
			chk(rd, ~i[0]);
		end
		$display("done t_page");
	endtask : t_page
	task t_rmw;
		req(DRC_OP_RMW, 16'h5a3c, 1, 0);
		chk(rd, 0);
		req(DRC_OP_READ, 16'h5a3c, 0, 0);
		chk(rd, 1);
		$display("done t_rmw");
	endtask : t_rmw
	task t_refresh;
		int   n;
		logic q;
		n = 0;
		q = 1;
		repeat (4 * PW) begin
			@(negedge i_sys_clk);
			if (q && !o_pins.ras_b)
				n++;
			q = o_pins.ras_b;
		end
		chk(n >= 3, 1);
		req(DRC_OP_READ, 16'hffff, 0, 0);
		chk(rd, 1);
		$display("done t_refresh");
	endtask : t_refresh
	task report_and_stop;
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	initial begin
		i_rst_b = 0;
		i_req_valid = 0;
		i_req = '0;
		repeat (2) @(negedge i_sys_clk);
		i_rst_b = 1;
		t_init;
		t_rw;
		t_page;
		t_rmw;
		t_refresh;
		report_and_stop;
	end
	// tests need well under a thousand cycles; allow ample slack
	initial begin
		repeat (20000) @(posedge i_sys_clk);
		fails++;
		report_and_stop;
	end
endmodule : dram_64k_x1_page_mode_tb_top
